// >>> bench/count_source.sv
// Partner: source driving the external count pin
`timescale 1ns/1ps
module count_source (
  input wire logic clk_sys,
  output logic pin
);
  initial pin = 1'b0;
  // Emits n pulses, each level held h clocks, then rests low
  task automatic pulse(input int n, input int h);
    repeat (n) begin
      repeat (h) @(posedge clk_sys);
      pin <= 1'b1;
      repeat (h) @(posedge clk_sys);
      pin <= 1'b0;
    end
  endtask
endmodule // count_source

// >>> bench/tb.sv
// Testbench: register-level tests of the prescaled timer
`timescale 1ns/1ps
module tb;
  import timer_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic sleep_mode = 1'b0;
  logic [7:0] rdata;
  logic irq;
  logic external_count_input;
  int fails = 0;
  int n_checks = 0;
  logic [7:0] cfgs [3] = '{8'h28, 8'h20, 8'h30};
  logic [7:0] ext_exp [3] = '{8'h08, 8'h04, 8'h04};

  timer0_prescaled_counter timer0_prescaled_counter_i (.clk_sys, .nrst,
    .addr, .wdata, .wr_stb, .rd_stb, .rdata, .irq, .sleep_mode,
    .external_count_input);
  count_source count_source_i (.clk_sys, .pin(external_count_input));

  always #2 clk_sys = ~clk_sys;

  // ==========================================================
  // Bus tasks, entered and left at a rising edge
  task automatic chk(input string nm, input logic [7:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    addr <= a;
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    @(negedge clk_sys);
    chk($sformatf("reg%0d", a), exp, rdata);
    @(posedge clk_sys);
  endtask
  task automatic idle(input int n);
    wr_stb <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic chk_irq(input logic exp);
    idle(0);
    @(negedge clk_sys);
    chk("irq", {7'h00, exp}, {7'h00, irq});
    @(posedge clk_sys);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watchdog far beyond the expected run of some 6700 clocks
  initial begin
    #100000;
    fails++;
    give_verdict();
  end

  // ==========================================================
  // Test sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int a = 1; a < 5; a++) begin
      rd(3'(a), (a == 1) ? CONFIG_RST : IRQ_RST);
    end
    for (int a = 5; a < 8; a++) begin
      wr(3'(a), 8'hff);
      rd(3'(a), 8'h00);
    end
    wr(OFS_COUNT, 8'h10);
    idle(40);
    rd(OFS_COUNT, 8'h1a);
    // Three counts per ratio, each 2^(ps+1) instruction cycles
    for (int ps = 0; ps < 8; ps++) begin
      wr(OFS_CONFIG, 8'(ps));
      rd(OFS_CONFIG, 8'(ps));
      wr(OFS_COUNT, 8'h00);
      idle(3 << (ps + 3));
      rd(OFS_COUNT, 8'h03);
    end
    wr(OFS_CONFIG, CONFIG_RST);
    wr(OFS_IRQ_CONTROL, 8'h00);
    wr(OFS_COUNT, COUNT_MAX);
    idle(8);
    rd(OFS_IRQ_CONTROL, 8'h02);
    chk_irq(1'b0);
    rd(OFS_IRQ_STATUS, 8'h01);
    rd(OFS_IRQ_STATUS, 8'h00);
    wr(OFS_IRQ_CONTROL, 8'h03);
    chk_irq(1'b1);
    idle(20);
    rd(OFS_IRQ_CONTROL, 8'h03);
    wr(OFS_IRQ_CONTROL, 8'h01);
    chk_irq(1'b0);
    wr(OFS_IRQ_CONTROL, 8'h00);
    wr(OFS_IRQ_MASK, 8'h01);
    wr(OFS_COUNT, COUNT_MAX);
    idle(8);
    chk_irq(1'b1);
    rd(OFS_IRQ_STATUS, 8'h01);
    chk_irq(1'b0);
    sleep_mode <= 1'b1;
    wr(OFS_COUNT, COUNT_MAX);
    rd(OFS_COUNT, COUNT_MAX);
    idle(40);
    chk_irq(1'b0);
    rd(OFS_COUNT, COUNT_MAX);
    rd(OFS_COUNT, COUNT_MAX);
    rd(OFS_IRQ_STATUS, 8'h00);
    // Pin pulses: bypassed, rising prescaled, falling prescaled
    // First setup is done asleep so the held count cannot roll over
    for (int i = 0; i < 3; i++) begin
      wr(OFS_CONFIG, cfgs[i]);
      wr(OFS_COUNT, 8'h00);
      sleep_mode <= 1'b0;
      idle(1);
      count_source_i.pulse(8, 2 + 4 * i);
      idle(8);
      rd(OFS_COUNT, ext_exp[i]);
    end
    rd(OFS_IRQ_STATUS, 8'h02);
    give_verdict();
  end
endmodule // tb

// >>> bench/timer_sva.sv
// Checker: bus, interrupt and sleep properties of the timer
`timescale 1ns/1ps
module timer_chk
  import timer_pkg::*;
#(
  parameter int PRESC_W = 8
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] rdata,
  input wire logic irq,
  input wire logic sleep_mode,
  input wire logic external_count_input
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // Read port
  AST_RD_IDLE: assert property (!rd_stb |=> rdata == 8'h00)
    else $error("rdata not zero");
  AST_RD_UNMAPPED: assert property (rd_stb && addr > 3'h4 |=> !rdata)
    else $error("unmapped read not zero");
  AST_COUNT_LOAD: assert property (wr_stb && addr == OFS_COUNT ##1
    rd_stb && addr == OFS_COUNT |=> rdata == $past(wdata, 2))
    else $error("count load lost");
  AST_CFG_BACK: assert property (wr_stb && addr == OFS_CONFIG ##1
    rd_stb && addr == OFS_CONFIG |=> rdata == ($past(wdata, 2) & 8'h3f))
    else $error("config readback");
  // ==========================================================
  // Interrupt and sleep
  AST_IRQ_FALL: assert property ($fell(irq) |->
    $past(wr_stb) || $past(rd_stb)) else $error("irq dropped alone");
  AST_IRQ_EN: assert property (wr_stb && addr == OFS_IRQ_CONTROL
    && wdata[1:0] == 2'h3 |=> irq) else $error("enabled flag no irq");
  AST_NO_WAKE: assert property ($rose(irq) && $past(sleep_mode)
    |-> $past(wr_stb)) else $error("irq rose asleep");
  AST_FROZEN: assert property (rd_stb && addr == OFS_COUNT && sleep_mode
    ##1 sleep_mode && !wr_stb ##1 rd_stb && addr == OFS_COUNT
    |=> rdata == $past(rdata, 2)) else $error("count moved asleep");
  COV_IRQ: cover property ($rose(irq));
  COV_SLEEP_RD: cover property (rd_stb && sleep_mode);
  COV_EXT: cover property ($rose(external_count_input));
endmodule // timer_chk

bind timer0_prescaled_counter timer_chk #(.PRESC_W(PRESC_W)) timer_chk_i (
  .clk_sys, .nrst, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .irq,
  .sleep_mode, .external_count_input
);

// >>> verilog/timer0_prescaled_counter.sv
// 8-bit timer/counter with prescaler, overflow flag and register port
`timescale 1ns/1ps

module timer0_prescaled_counter
  import timer_pkg::*;
#(
  parameter int PRESC_W = 8
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  output logic irq,
  input wire logic sleep_mode,
  input wire logic external_count_input
);

  // ==========================================================
  // State
  logic [1:0] phase_reg;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  cfg_t cfg_reg;
  cfg_t cfg_next;
  logic [PRESC_W-1:0] presc_reg;
  logic [PRESC_W-1:0] presc_next;
  logic ie_reg;
  logic ie_next;
  logic flag_reg;
  logic flag_next;
  logic [1:0] status_reg;
  logic [1:0] status_next;
  logic [1:0] mask_reg;
  logic [1:0] mask_next;
  logic pin_prev_reg;
  logic pin_prev_next;
  logic samp_reg;
  logic samp_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic irq_reg;
  logic irq_next;

  // ==========================================================
  // Decoding helpers

  // Low prescaler bits that must be all ones at the terminal count
  function automatic logic [PRESC_W-1:0] ratio_mask(
    input logic [2:0] sel
  );
    logic [PRESC_W-1:0] m;
    m = '0;
    for (int i = 0; i < PRESC_W; i++) begin
      if (i <= int'(sel)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // ==========================================================
  // Register port decode
  wire sel_count = (addr == OFS_COUNT);
  wire sel_config = (addr == OFS_CONFIG);
  wire sel_irqc = (addr == OFS_IRQ_CONTROL);
  wire sel_status = (addr == OFS_IRQ_STATUS);
  wire sel_mask = (addr == OFS_IRQ_MASK);
  wire wr_count = wr_stb && sel_count;
  wire wr_config = wr_stb && sel_config;
  wire wr_irqc = wr_stb && sel_irqc;
  wire wr_mask = wr_stb && sel_mask;
  wire rd_status = rd_stb && sel_status;

  // ==========================================================
  // Instruction clock phases
  wire at_q2 = (phase_reg == PHASE_Q2);
  wire at_q4 = (phase_reg == PHASE_Q4);
  wire sample_now = at_q2 || at_q4;

  // Counting is frozen while the processor sleeps
  wire run = !sleep_mode;

  src_mode_t mode;
  assign mode = cfg_reg.ext_source ? SRC_EXTERNAL : SRC_TIMER;

  // ==========================================================
  // Prescaler input and terminal count
  wire pin_eff = external_count_input ^ cfg_reg.edge_fall;
  // Edges judged on the raw pin, so flipping edge_fall fakes no prescaler step
  wire pin_rise = external_count_input && !pin_prev_reg;
  wire pin_fall = !external_count_input && pin_prev_reg;
  wire pin_edge = cfg_reg.edge_fall ? pin_fall : pin_rise;
  wire [PRESC_W-1:0] tc_mask = ratio_mask(cfg_reg.prescale_select);
  wire presc_tc = ((presc_reg & tc_mask) == tc_mask);
  wire in_path = !cfg_reg.prescaler_bypass;

  // Prescaler is stepped by the chosen source only, never by a watchdog
  wire presc_step = run && in_path &&
    ((mode == SRC_TIMER) ? at_q4 : pin_edge);

  // Output level of the prescaler seen by the synchronizer
  wire ext_level = in_path ?
    presc_reg[cfg_reg.prescale_select] : pin_eff;

  // Rising edge of the level as seen at a Q2 or Q4 sample
  wire ext_inc = run && sample_now && ext_level && !samp_reg;

  // Timer mode advance: every Q4, or at the prescaler wrap
  wire tmr_inc = run && at_q4 &&
    (cfg_reg.prescaler_bypass || presc_tc);

  wire count_inc = (mode == SRC_TIMER) ? tmr_inc : ext_inc;

  // Rollover; a software load in the same cycle takes precedence
  wire overflow = count_inc && (count_reg == COUNT_MAX) &&
    !wr_count;

  // ==========================================================
  // Next values of counter and prescaler

  // Software load beats increment; sleep holds the value
  assign count_next = wr_count ? wdata :
    (count_inc ? count_reg + 8'h01 : count_reg);

  // A write to the count register clears the prescaler
  assign presc_next = wr_count ? '0 :
    (presc_step ? presc_reg + 1'b1 : presc_reg);

  // Synchronizer sample updates only in Q2 and Q4 while awake
  assign samp_next = (run && sample_now) ? ext_level : samp_reg;

  // ==========================================================
  // Next values of configuration and interrupt registers
  assign cfg_next = wr_config ?
    cfg_t'({2'b00, wdata[5:0]}) : cfg_reg;

  // Next values of enable, mask and pin history
  assign ie_next = wr_irqc ? wdata[IRQC_IE_BIT] : ie_reg;
  assign mask_next = wr_mask ? wdata[1:0] : mask_reg;
  assign pin_prev_next = run ? external_count_input : pin_prev_reg;

  // Set wins over a software clear; hardware only ever sets
  assign flag_next = overflow ||
    (wr_irqc ? wdata[IRQC_FLAG_BIT] : flag_reg);

  // Sticky event bits, read clears them, a new event wins
  wire [1:0] events = {ext_inc && (mode == SRC_EXTERNAL), overflow};
  assign status_next = events | (rd_status ? 2'b00 : status_reg);

  // Interrupt request from the gated flag or unmasked status
  assign irq_next = (flag_next && (wr_irqc ?
    wdata[IRQC_IE_BIT] : ie_reg)) ||
    |(status_next & (wr_mask ? wdata[1:0] : mask_reg));

  // ==========================================================
  // Read data mux; the prescaler has no address at all
  always_comb begin
    rdata_next = 8'h00;
    if (rd_stb) begin
      unique case (1'b1)
        sel_count: rdata_next = count_reg;
        sel_config: rdata_next = cfg_reg;
        sel_irqc: rdata_next = {6'h00, flag_reg, ie_reg};
        sel_status: rdata_next = {6'h00, status_reg};
        sel_mask: rdata_next = {6'h00, mask_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Instruction phase counter runs freely from reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      phase_reg <= PHASE_RST;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  // Count register, loaded by software or advanced by the counter
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      count_reg <= COUNT_RST;
    end else begin
      count_reg <= count_next;
    end
  end

  // Prescaler count, private to this timer
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      presc_reg <= '0;
    end else begin
      presc_reg <= presc_next;
    end
  end

  // Synchronizer sample of the prescaler output
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      samp_reg <= 1'b0;
    end else begin
      samp_reg <= samp_next;
    end
  end

  // Pin history; resets to the idle low level to avoid a false edge
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= pin_prev_next;
    end
  end

  // Configuration register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfg_reg <= cfg_t'(CONFIG_RST);
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // Overflow interrupt enable
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ie_reg <= 1'b0;
    end else begin
      ie_reg <= ie_next;
    end
  end

  // Overflow flag; only reset or software take it down
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // Sticky event status
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      status_reg <= IRQ_RST[1:0];
    end else begin
      status_reg <= status_next;
    end
  end

  // Event mask
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mask_reg <= IRQ_RST[1:0];
    end else begin
      mask_reg <= mask_next;
    end
  end

  // Registered read data, zero outside the answer cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Registered interrupt request
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign rdata = rdata_reg;
  assign irq = irq_reg;

endmodule // timer0_prescaled_counter

// >>> verilog/timer_pkg.sv
// Package: register map, field layout and constants of the prescaled timer
package timer_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [2:0] OFS_COUNT = 3'h0;
  localparam logic [2:0] OFS_CONFIG = 3'h1;
  localparam logic [2:0] OFS_IRQ_CONTROL = 3'h2;
  localparam logic [2:0] OFS_IRQ_STATUS = 3'h3;
  localparam logic [2:0] OFS_IRQ_MASK = 3'h4;

  // ==========================================================
  // Field positions
  localparam int IRQC_IE_BIT = 0;
  localparam int IRQC_FLAG_BIT = 1;
  localparam int EVT_OVERFLOW_BIT = 0;
  localparam int EVT_EXT_EDGE_BIT = 1;

  // ==========================================================
  // Reset values and count maximum
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] CONFIG_RST = 8'h08;
  localparam logic [7:0] IRQ_RST = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;

  // ==========================================================
  // Instruction cycle timing: four system clocks, Q1 to Q4
  localparam logic [1:0] PHASE_RST = 2'h0;
  localparam logic [1:0] PHASE_Q2 = 2'h1;
  localparam logic [1:0] PHASE_Q4 = 2'h3;

  // Configuration register layout
  typedef struct packed {
    logic [1:0] spare;
    logic ext_source;
    logic edge_fall;
    logic prescaler_bypass;
    logic [2:0] prescale_select;
  } cfg_t;

  // Source of counter advance
  typedef enum logic {
    SRC_TIMER,
    SRC_EXTERNAL
  } src_mode_t;

endpackage
